// ### verilog/digit_timing_pkg.sv
package digit_timing_pkg;

  // Phase and slot structure
  localparam int          PHASES_PER_SLOT = 4;
  localparam logic [3:0]  PHASE_RESET     = 4'h1;   // Phase 1 after reset
  localparam int          OUT_PHASE       = 0;      // Phase n, bit visible at amplifier output
  localparam int          GATE_PHASE      = 3;      // Phase n-1, gate inputs act here
  localparam int          BLEND_PHASE     = 1;      // Phase after the ring outputs, digit pulse is out

  // Loop lengths in slots
  localparam int          STORE_SLOTS     = 8;
  localparam int          FLOP_SLOTS      = 1;
  localparam int          LONG_SHORT      = 11;
  localparam int          LONG_NOMINAL    = 12;
  localparam int          LONG_EXTENDED   = 13;

  // Countdown rings and word period
  localparam int          RING_A_SLOTS    = 3;
  localparam int          RING_B_SLOTS    = 4;
  localparam int          WORD_SLOTS      = 12;
  localparam int          DIGIT_W         = 4;
  localparam logic [3:0]  DIGIT_NONE      = 4'h0;

  // Entry buffer in front of the long loop
  localparam int          ENTRY_DEPTH     = 8;

  // Write and inhibit lines of a simple storage loop
  typedef struct packed {
    logic write;
    logic inhibit;
  } loop_ctl_t;

  // Gate terms of the example dynamic flip-flop
  typedef struct packed {
    logic t;
    logic s;
    logic r;
    logic b;
    logic a;
    logic e;
    logic d;
  } flop_terms_t;

  // Control lines of the long loop
  typedef struct packed {
    logic write;
    logic erase;
    logic lengthen;
    logic shorten;
  } long_ctl_t;

  // Buffered entry: bit written during the slot of the named digit
  typedef struct packed {
    logic [3:0] digit;
    logic       value;
  } long_entry_t;

  localparam int          ENTRY_W         = $bits(long_entry_t);

endpackage : digit_timing_pkg

// ### verilog/entry_fifo.sv
`timescale 1ns/10ps

module entry_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             clk_en_in,
  input  wire logic             wr_valid_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  wr_ready_out,
  output logic                  rd_valid_out,
  output logic [WIDTH-1:0]      rd_data_out,
  input  wire logic             rd_ready_in
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // Extra pointer bit separates full from empty
  always_comb
  begin
    full         = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    empty        = (wr_ptr == rd_ptr);
    wr_ready_out = ~full;
    rd_valid_out = ~empty;
    rd_data_out  = mem[rd_ptr[AW-1:0]];
    push         = clk_en_in & wr_valid_in & ~full;
    pop          = clk_en_in & rd_ready_in & ~empty;
    next_wr_ptr  = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr  = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  // Pointer registers
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage, written only on an accepted push
  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wr_ptr[AW-1:0]] <= wr_data_in;
    end
  end

endmodule : entry_fifo

// ### verilog/serial_digit_timing_generator.sv
`timescale 1ns/10ps

module serial_digit_timing_generator (
  input  wire logic                            clk_in,
  input  wire logic                            sys_rst_in,
  input  wire logic                            clk_en_in,
  input  wire digit_timing_pkg::loop_ctl_t     store_ctl_in,
  output logic                                 store_out,
  input  wire digit_timing_pkg::flop_terms_t   flop_terms_in,
  output logic                                 flop_out,
  input  wire digit_timing_pkg::long_ctl_t     long_ctl_in,
  input  wire logic                            entry_valid_in,
  input  wire digit_timing_pkg::long_entry_t   entry_in,
  output logic                                 entry_ready_out,
  output logic                                 long_out,
  output logic [3:0]                           phase_tick_out,
  output logic [2:0]                           ring_a_out,
  output logic [3:0]                           ring_b_out,
  output logic [11:0]                          digit_out,
  output logic [3:0]                           digit_num_out
);

  localparam int STORE_LEN = digit_timing_pkg::STORE_SLOTS * digit_timing_pkg::PHASES_PER_SLOT - 1;
  localparam int FLOP_LEN  = digit_timing_pkg::FLOP_SLOTS * digit_timing_pkg::PHASES_PER_SLOT - 1;
  localparam int LONG_LEN  = digit_timing_pkg::LONG_EXTENDED * digit_timing_pkg::PHASES_PER_SLOT - 1;
  localparam int A_LEN     = digit_timing_pkg::RING_A_SLOTS * digit_timing_pkg::PHASES_PER_SLOT;
  localparam int B_LEN     = digit_timing_pkg::RING_B_SLOTS * digit_timing_pkg::PHASES_PER_SLOT;

  // Delay-line tap that closes the long loop at the chosen length in slots
  function automatic int long_tap(input logic lengthen, input logic shorten);
    int slots;
    slots = digit_timing_pkg::LONG_NOMINAL;
    if (lengthen && !shorten)
    begin
      slots = digit_timing_pkg::LONG_EXTENDED;
    end
    else if (shorten && !lengthen)
    begin
      slots = digit_timing_pkg::LONG_SHORT;
    end
    return slots * digit_timing_pkg::PHASES_PER_SLOT - 2;
  endfunction : long_tap

  // Ring output index (1-based) for a residue, zero residue selecting the last
  function automatic int ring_sel(input int j, input int modulus);
    int res;
    res = j % modulus;
    return (res == 0) ? modulus : res;
  endfunction : ring_sel

  // Recirculating gate: keep unless inhibited, then OR in the new bit
  function automatic logic loop_gate(input logic recirc, input logic inhibit_neg, input logic write);
    return (recirc & inhibit_neg) | write;
  endfunction : loop_gate

  logic [3:0]              phase_tick;
  logic [3:0]              next_phase_tick;
  logic                    gate_time;

  logic                    store_amp;
  logic [STORE_LEN-1:0]    store_line;
  logic                    next_store_amp;
  logic [STORE_LEN-1:0]    next_store_line;

  logic                    flop_amp;
  logic [FLOP_LEN-1:0]     flop_line;
  logic                    next_flop_amp;
  logic [FLOP_LEN-1:0]     next_flop_line;
  logic                    flop_set;
  logic                    flop_reset;

  logic                    long_amp;
  logic [LONG_LEN-1:0]     long_line;
  logic                    next_long_amp;
  logic [LONG_LEN-1:0]     next_long_line;
  logic                    long_recirc;

  logic [A_LEN-1:0]        a_line;
  logic [B_LEN-1:0]        b_line;
  logic [A_LEN-1:0]        next_a_line;
  logic [B_LEN-1:0]        next_b_line;
  logic [2:0]              ring_a;
  logic [3:0]              ring_b;
  logic [2:0]              ring_a_neg;
  logic [3:0]              ring_b_neg;

  logic [11:0]             digit;
  logic [11:0]             next_digit;
  logic [3:0]              digit_num;
  logic [3:0]              next_digit_num;

  digit_timing_pkg::long_entry_t entry_head;
  logic                    entry_head_valid;
  logic                    entry_take;
  logic                    entry_write;

  // Entry buffer for bits aimed at a digit slot of the long loop
  entry_fifo #(
    .WIDTH (digit_timing_pkg::ENTRY_W),
    .DEPTH (digit_timing_pkg::ENTRY_DEPTH)
  ) u_entry_fifo (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .clk_en_in    (clk_en_in),
    .wr_valid_in  (entry_valid_in),
    .wr_data_in   (entry_in),
    .wr_ready_out (entry_ready_out),
    .rd_valid_out (entry_head_valid),
    .rd_data_out  (entry_head),
    .rd_ready_in  (entry_take)
  );

  // Four-phase clock ring, one cycle per phase
  always_comb
  begin
    next_phase_tick = phase_tick;
    if (clk_en_in)
    begin
      next_phase_tick = {phase_tick[2:0], phase_tick[3]};
    end
    gate_time = phase_tick[digit_timing_pkg::GATE_PHASE];
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      phase_tick <= digit_timing_pkg::PHASE_RESET;
    end
    else
    begin
      phase_tick <= next_phase_tick;
    end
  end

  // Basic storage loop: gate, amplifier register, delay line
  always_comb
  begin
    next_store_amp  = store_amp;
    next_store_line = store_line;
    if (clk_en_in)
    begin
      next_store_amp  = loop_gate(store_line[STORE_LEN-1],
                                  ~(gate_time & store_ctl_in.inhibit),
                                  gate_time & store_ctl_in.write);
      next_store_line = {store_line[STORE_LEN-2:0], store_amp};
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      store_amp  <= 1'b0;
      store_line <= '0;
    end
    else
    begin
      store_amp  <= next_store_amp;
      store_line <= next_store_line;
    end
  end

  // Example dynamic flip-flop, one slot around
  always_comb
  begin
    flop_set       = (flop_terms_in.t & flop_terms_in.s & flop_terms_in.r)
                   | (flop_terms_in.b & ~flop_terms_in.a);
    flop_reset     = ~flop_terms_in.e | flop_terms_in.d;
    next_flop_amp  = flop_amp;
    next_flop_line = flop_line;
    if (clk_en_in)
    begin
      next_flop_amp  = loop_gate(flop_line[FLOP_LEN-1],
                                 ~(gate_time & flop_reset),
                                 gate_time & flop_set);
      next_flop_line = {flop_line[FLOP_LEN-2:0], flop_amp};
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      flop_amp  <= 1'b0;
      flop_line <= '0;
    end
    else
    begin
      flop_amp  <= next_flop_amp;
      flop_line <= next_flop_line;
    end
  end

  // Buffered entry lands in the slot whose digit number matches
  always_comb
  begin
    entry_write = gate_time & entry_head_valid & (entry_head.digit == digit_num)
                & (digit_num != digit_timing_pkg::DIGIT_NONE);  // Digit zero never drains
    entry_take  = entry_write;
  end

  // Long loop with selectable length, entry gate and erase line
  always_comb
  begin
    long_recirc    = long_line[long_tap(long_ctl_in.lengthen, long_ctl_in.shorten)];
    next_long_amp  = long_amp;
    next_long_line = long_line;
    if (clk_en_in)
    begin
      next_long_amp  = loop_gate(long_recirc,
                                 ~entry_write,
                                 gate_time & (long_ctl_in.write | (entry_write & entry_head.value)));
      next_long_line = {long_line[LONG_LEN-2:1],
                        long_line[0] & ~long_ctl_in.erase,
                        long_amp};
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      long_amp  <= 1'b0;
      long_line <= '0;
    end
    else
    begin
      long_amp  <= next_long_amp;
      long_line <= next_long_line;
    end
  end

  // Ring taps; positive outputs feed blenders, inverted ones feed inhibits
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      ring_a[i] = a_line[i * digit_timing_pkg::PHASES_PER_SLOT];
    end
    for (int i = 0; i < 4; i++)
    begin
      ring_b[i] = b_line[i * digit_timing_pkg::PHASES_PER_SLOT];
    end
    ring_a_neg = ~{a_line[11], a_line[7], a_line[3]};
    ring_b_neg = ~{b_line[15], b_line[11], b_line[7], b_line[3]};
  end

  // Countdown rings: entry gate passes unless a delayed earlier output is present
  always_comb
  begin
    next_a_line = a_line;
    next_b_line = b_line;
    if (clk_en_in)
    begin
      next_a_line = {a_line[A_LEN-2:0],
                     gate_time & ring_a_neg[0] & ring_a_neg[1]};
      next_b_line = {b_line[B_LEN-2:0],
                     gate_time & ring_b_neg[0] & ring_b_neg[1] & ring_b_neg[2]};
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      a_line <= '0;
      b_line <= '0;
    end
    else
    begin
      a_line <= next_a_line;
      b_line <= next_b_line;
    end
  end

  // Blenders: one AND per digit, plus the running digit number
  always_comb
  begin
    next_digit     = digit;
    next_digit_num = digit_num;
    if (clk_en_in)
    begin
      for (int j = 1; j <= digit_timing_pkg::WORD_SLOTS; j++)
      begin
        next_digit[j-1] = ring_a[ring_sel(j, digit_timing_pkg::RING_A_SLOTS) - 1]
                        & ring_b[ring_sel(j, digit_timing_pkg::RING_B_SLOTS) - 1];
      end
      for (int j = 1; j <= digit_timing_pkg::WORD_SLOTS; j++)
      begin
        if (digit[j-1])
        begin
          next_digit_num = 4'(j);
        end
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      digit     <= '0;
      digit_num <= digit_timing_pkg::DIGIT_NONE;
    end
    else
    begin
      digit     <= next_digit;
      digit_num <= next_digit_num;
    end
  end

  // Outputs straight from the phase ring, amplifier, ring line and blender registers
  always_comb
  begin
    phase_tick_out = phase_tick;
    store_out      = store_amp;
    flop_out       = flop_amp;
    long_out       = long_amp;
    ring_a_out     = ring_a;
    ring_b_out     = ring_b;
    digit_out      = digit;
    digit_num_out  = digit_num;
  end

endmodule : serial_digit_timing_generator

// ### verification/sdt_sva.sv
`timescale 1ns/10ps

// Port checker for the digit timing generator
module sdt_sva (
  input wire logic                          clk_in,
  input wire logic                          sys_rst_in,
  input wire logic                          clk_en_in,
  input wire digit_timing_pkg::loop_ctl_t   store_ctl_in,
  input wire logic                          store_out,
  input wire digit_timing_pkg::flop_terms_t flop_terms_in,
  input wire logic                          flop_out,
  input wire logic                          long_out,
  input wire logic                          entry_ready_out,
  input wire logic [3:0]                    phase_tick_out,
  input wire logic [2:0]                    ring_a_out,
  input wire logic [3:0]                    ring_b_out,
  input wire logic [11:0]                   digit_out
);
  logic [2:0]  ra_q;
  logic [3:0]  rb_q;
  logic [11:0] exp_d;
  logic        set_c;
  logic        clr_c;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in || !clk_en_in);

  // Set and reset terms of the example flip-flop
  assign set_c = (flop_terms_in.t & flop_terms_in.s & flop_terms_in.r) | (flop_terms_in.b & ~flop_terms_in.a);
  assign clr_c = ~flop_terms_in.e | flop_terms_in.d;

  // Ring outputs of the last enabled cycle, feeding the coincidence check
  always_ff @(posedge clk_in)
  begin
    ra_q <= sys_rst_in ? 3'h0 : clk_en_in ? ring_a_out : ra_q;
    rb_q <= sys_rst_in ? 4'h0 : clk_en_in ? ring_b_out : rb_q;
  end

  // Expected AND of A and B outputs per digit, zero residue as last
  always_comb
  begin
    for (int j = 1; j <= 12; j++)
      exp_d[j-1] = ra_q[(j + 2) % 3] & rb_q[(j + 3) % 4];
  end

  AST_PHASE_ROT:
    assert property (!sys_rst_in && clk_en_in |=> phase_tick_out == {$past(phase_tick_out[2:0]), $past(phase_tick_out[3])})
    else $error("phase did not advance");
  AST_RING_START:
    assert property ($fell(sys_rst_in) |-> ##4 ring_a_out == 3'h1 && ring_b_out == 4'h1)
    else $error("rings did not start in slot one");
  AST_RING_A_SEQ:
    assert property (ring_a_out == 3'h1 |-> ##4 ring_a_out == 3'h2 ##4 ring_a_out == 3'h4 ##4 ring_a_out == 3'h1)
    else $error("three-slot ring out of order");
  AST_RING_B_SEQ:
    assert property (ring_b_out == 4'h1 |-> ##4 ring_b_out == 4'h2 ##4 ring_b_out == 4'h4 ##4 ring_b_out == 4'h8
                     ##4 ring_b_out == 4'h1)
    else $error("four-slot ring out of order");
  AST_RING_PHASE:
    assert property (ring_a_out != 3'h0 || ring_b_out != 4'h0 |-> phase_tick_out[0] && $onehot(ring_a_out)
                     && $onehot(ring_b_out))
    else $error("ring pulse in wrong phase");
  AST_DIGIT_AND:
    assert property (digit_out == exp_d)
    else $error("digit pulse not the ring coincidence");
  AST_FLOP_SET:
    assert property (phase_tick_out[3] && set_c |=> flop_out)
    else $error("flip-flop did not set");
  AST_FLOP_CLR:
    assert property (phase_tick_out[3] && !set_c && clr_c |=> !flop_out [*4])
    else $error("flip-flop did not clear");
  AST_STORE_GATE:
    assert property (phase_tick_out[3] && (store_ctl_in.write || store_ctl_in.inhibit)
                     |=> store_out == $past(store_ctl_in.write))
    else $error("storage loop write or inhibit lost");
  AST_OUT_PHASE:
    assert property (store_out || flop_out || long_out |-> phase_tick_out[0])
    else $error("loop output outside phase one");

  // Main scenarios
  COV_T12: cover property (ring_a_out[2] && ring_b_out[3]);
  COV_FLOP: cover property (phase_tick_out[3] && set_c ##1 flop_out);
  COV_FULL: cover property (!entry_ready_out);
endmodule : sdt_sva

// ### verification/ctl_partner.sv
`timescale 1ns/10ps

// Control logic beside the loops: store, flip-flop and write requests stand only in the gate phase
module ctl_partner (
  input  wire logic                          clk_in,
  input  wire logic [3:0]                    phase_in,
  input  wire logic                          long_in,
  input  wire digit_timing_pkg::loop_ctl_t   store_req_in,
  input  wire digit_timing_pkg::flop_terms_t flop_req_in,
  input  wire logic                          write_req_in,
  input  wire logic                          erase_en_in,
  input  wire logic [1:0]                    len_in,
  output digit_timing_pkg::loop_ctl_t        store_ctl_out,
  output digit_timing_pkg::flop_terms_t      flop_terms_out,
  output digit_timing_pkg::long_ctl_t        long_ctl_out
);
  // Outside the gate phase the store, flip-flop and write lines carry the inverse, which must be ignored; erase and length lines do not
  always @(posedge clk_in)
  begin
    store_ctl_out         <= phase_in[2] ? store_req_in : ~store_req_in;
    flop_terms_out        <= phase_in[2] ? flop_req_in : ~flop_req_in;
    long_ctl_out.write    <= phase_in[2] ? write_req_in : ~write_req_in;
    long_ctl_out.erase    <= erase_en_in & long_in;
    long_ctl_out.lengthen <= len_in[1];
    long_ctl_out.shorten  <= len_in[0];
  end
endmodule : ctl_partner

// ### verification/serial_digit_timing_generator_tb.sv
`timescale 1ns/10ps

module serial_digit_timing_generator_tb;
  logic                          clk_in;
  logic                          sys_rst_in;
  logic                          clk_en_in;
  logic                          entry_valid_in;
  logic                          write_req;
  logic                          erase_en;
  logic [1:0]                    len_sel;
  digit_timing_pkg::loop_ctl_t   store_req;
  digit_timing_pkg::flop_terms_t flop_req;
  digit_timing_pkg::loop_ctl_t   store_ctl_in;
  digit_timing_pkg::flop_terms_t flop_terms_in;
  digit_timing_pkg::long_ctl_t   long_ctl_in;
  digit_timing_pkg::long_entry_t entry_in;
  logic                          store_out;
  logic                          flop_out;
  logic                          long_out;
  logic                          entry_ready_out;
  logic [3:0]                    phase_tick_out;
  logic [2:0]                    ring_a_out;
  logic [3:0]                    ring_b_out;
  logic [11:0]                   digit_out;
  logic [3:0]                    digit_num_out;
  logic [31:0]                   rnd;
  int                            failures;
  int                            n_tests;
  int                            cycles;
  int                            c;
  int                            p;
  int                            s;
  int                            len;
  int                            nb;
  logic                          fl;
  logic                          full;
  logic                          st [8];
  logic                          hist [1024];
  digit_timing_pkg::long_entry_t eq [$];

  serial_digit_timing_generator u_serial_digit_timing_generator (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in), .store_ctl_in(store_ctl_in),
    .store_out(store_out), .flop_terms_in(flop_terms_in), .flop_out(flop_out), .long_ctl_in(long_ctl_in),
    .entry_valid_in(entry_valid_in), .entry_in(entry_in), .entry_ready_out(entry_ready_out),
    .long_out(long_out), .phase_tick_out(phase_tick_out), .ring_a_out(ring_a_out), .ring_b_out(ring_b_out),
    .digit_out(digit_out), .digit_num_out(digit_num_out)
  );

  ctl_partner u_ctl_partner (
    .clk_in(clk_in), .phase_in(phase_tick_out), .long_in(long_out), .store_req_in(store_req),
    .flop_req_in(flop_req), .write_req_in(write_req), .erase_en_in(erase_en), .len_in(len_sel),
    .store_ctl_out(store_ctl_in), .flop_terms_out(flop_terms_in), .long_ctl_out(long_ctl_in)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t ns: output %h, model %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task automatic do_reset;
    sys_rst_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
  endtask : do_reset

  // Random slot of loop traffic, changed after the edge ending phase two
  task automatic rand_slot;
    @(posedge clk_in iff phase_tick_out[1]);
    rnd = lfsr(rnd);
    store_req <= rnd[1:0];
    flop_req  <= rnd[8:2];
    write_req <= &rnd[11:9];
    erase_en  <= rnd[12];
    len_sel   <= rnd[14:13];
  endtask : rand_slot

  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // Reference model, stepped with the inputs of the cycle that ends
  always @(posedge clk_in)
  begin
    p = c % 4;
    s = c / 4;
    full = eq.size() >= 8;
    if (sys_rst_in)
    begin
      c = 0;
      fl = 1'b0;
      st = '{default: 1'b0};
      hist = '{default: 1'b0};
      eq.delete();
    end
    else if (clk_en_in)
    begin
      if (p == 1 && long_ctl_in.erase)
        hist[s % 1024] = 1'b0;
      if (p == 3)
      begin
        st[(s + 1) % 8] = (st[(s + 1) % 8] & ~store_ctl_in.inhibit) | store_ctl_in.write;
        fl = (fl & flop_terms_in.e & ~flop_terms_in.d) | (flop_terms_in.b & ~flop_terms_in.a)
             | (flop_terms_in.t & flop_terms_in.s & flop_terms_in.r);
        len = (long_ctl_in.lengthen == long_ctl_in.shorten) ? 12 : long_ctl_in.lengthen ? 13 : 11;
        nb = (s + 1 >= len) ? int'(hist[(s + 1 - len) % 1024]) : 0;
        if (s >= 1 && eq.size() > 0 && int'(eq[0].digit) == (s - 1) % 12 + 1)
        begin
          nb = int'(eq[0].value);
          void'(eq.pop_front());
        end
        hist[(s + 1) % 1024] = (nb != 0) | long_ctl_in.write;
      end
      if (entry_valid_in && !full)
        eq.push_back(entry_in);
      c++;
    end
  end

  // Compare all outputs with the model mid-cycle
  always @(negedge clk_in)
  begin
    if (!sys_rst_in)
    begin
      p = c % 4;
      s = c / 4;
      check(12'(phase_tick_out), 12'(1 << p));
      check(12'(ring_a_out), (p == 0 && s >= 1) ? 12'(1 << ((s - 1) % 3)) : 12'h0);
      check(12'(ring_b_out), (p == 0 && s >= 1) ? 12'(1 << ((s - 1) % 4)) : 12'h0);
      check(digit_out, (p == 1 && s >= 1) ? 12'(1 << ((s - 1) % 12)) : 12'h0);
      check(12'(digit_num_out), 12'((s >= 1 && p >= 2) ? (s - 1) % 12 + 1 : (s >= 2) ? (s - 2) % 12 + 1 : 0));
      check(12'(store_out), 12'(p == 0 && st[s % 8]));
      check(12'(flop_out), 12'(p == 0 && fl));
      check(12'(long_out), 12'(p == 0 && hist[s % 1024]));
      check(12'(entry_ready_out), 12'(eq.size() < 8));
    end
  end

  // Cycle ceiling against a hang
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      failures++;
      $display("[ERR] %0t ns: run did not finish", $time);
      give_verdict();
    end
  end

  initial
  begin
    rnd = 32'h8d552153;
    failures = 0;
    n_tests = 0;
    cycles = 0;
    clk_en_in = 1'b1;
    entry_valid_in = 1'b0;
    entry_in = 5'h00;
    store_req = 2'h0;
    flop_req = 7'h02;
    write_req = 1'b0;
    erase_en = 1'b0;
    len_sel = 2'h0;
    do_reset();
    repeat (36) @(posedge clk_in iff phase_tick_out[0]);
    $display("Test word timing done");
    // Enable low for six cycles: every output must hold still
    clk_en_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    clk_en_in <= 1'b1;
    $display("Test clock enable done");
    repeat (400) rand_slot();
    $display("Test random loops done");
    @(posedge clk_in);
    store_req <= 2'h0;
    flop_req <= 7'h02;
    write_req <= 1'b0;
    erase_en <= 1'b0;
    len_sel <= 2'h0;
    // Digit zero entries never drain, so the buffer fills and refuses
    entry_valid_in <= 1'b1;
    repeat (12) @(posedge clk_in);
    entry_valid_in <= 1'b0;
    $display("Test buffer full done");
    do_reset();
    $display("Test mid-run reset done");
    // Nine entries: digit one drains the head as the eighth goes in, so the last finds room at once
    for (int i = 1; i <= 9; i++)
    begin
      rnd = lfsr(rnd);
      entry_valid_in <= 1'b1;
      entry_in <= {4'(i), rnd[0]};
      @(posedge clk_in iff entry_ready_out);
    end
    entry_valid_in <= 1'b0;
    repeat (60) @(posedge clk_in iff phase_tick_out[0]);
    $display("Test buffer drain done");
    give_verdict();
  end
endmodule : serial_digit_timing_generator_tb

bind serial_digit_timing_generator sdt_sva u_sdt_sva (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in), .store_ctl_in(store_ctl_in),
  .store_out(store_out),
  .flop_terms_in(flop_terms_in), .flop_out(flop_out), .long_out(long_out), .entry_ready_out(entry_ready_out),
  .phase_tick_out(phase_tick_out), .ring_a_out(ring_a_out), .ring_b_out(ring_b_out), .digit_out(digit_out)
);
